/* File: hdl/tsens_pkg.sv */
/*
  Constants, register map and types of the serial register interface of
  the temperature sensor, and the limit comparison behind it.
  Assumes a single system clock; all users import the whole package.
*/
package tsens_pkg;

  localparam int unsigned DATA_W      = 16;
  localparam int unsigned BYTE_W      = 8;
  localparam int unsigned HYST_W      = 4;
  localparam int unsigned BITCNT_W    = 5;
  localparam int unsigned ONES_W      = 6;
  // One degree is this many temperature LSBs to the left of bit zero.
  localparam int unsigned DEG_LSB     = 7;

  typedef logic [2:0]        reg_addr_t;
  typedef logic [DATA_W-1:0] word_t;

  localparam reg_addr_t ADDR_TEMP   = 3'h2;
  localparam reg_addr_t ADDR_IDENT  = 3'h3;
  localparam reg_addr_t ADDR_CRIT   = 3'h4;
  localparam reg_addr_t ADDR_HYST   = 3'h5;
  localparam reg_addr_t ADDR_HIGH   = 3'h6;
  localparam reg_addr_t ADDR_LOW    = 3'h7;

  localparam word_t          CRIT_RST    = 16'h4980;
  localparam logic [7:0]     HYST_RST    = 8'h05;
  localparam word_t          HIGH_RST    = 16'h2000;
  localparam word_t          LOW_RST     = 16'h0500;
  // Identification value is arbitrary.
  localparam logic [7:0]     IDENT_DEF   = 8'h5a;

  localparam int unsigned    CMD_TOP_BIT = 7;
  localparam int unsigned    DIR_BIT     = 6;
  localparam int unsigned    ADDR_MSB    = 5;
  localparam int unsigned    ADDR_LSB    = 3;
  localparam int unsigned    CONT_BIT    = 2;
  localparam logic [7:0]     CONT_CMD    = 8'h54;

  localparam logic [BITCNT_W-1:0] BYTE_LAST = 5'h7;
  localparam logic [BITCNT_W-1:0] WORD_LAST = 5'hf;
  localparam logic [ONES_W-1:0]   ONES_RUN  = 6'h20;

  typedef enum logic [2:0] {
    ST_CMD,
    ST_WRITE,
    ST_READ,
    ST_CONT,
    ST_DONE
  } link_state_t;

endpackage

/* File: hdl/limit_if.sv */
/*
  Bundle between the serial register block and the limit comparator.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface limit_if;
  import tsens_pkg::*;
  logic                     ce;
  word_t                    temp;
  word_t                    high;
  word_t                    low;
  word_t                    crit;
  logic [HYST_W-1:0]        hyst;
  logic                     cmp_mode;
  logic                     rd_evt;
  logic                     alarm;
  logic                     critical;

  modport ctrl (output ce, temp, high, low, crit, hyst, cmp_mode, rd_evt,
                input alarm, critical);
  modport cmp  (input ce, temp, high, low, crit, hyst, cmp_mode, rd_evt,
                output alarm, critical);
endinterface

/* File: hdl/limit_compare.sv */
/*
  Limit comparator: applies hysteresis to the high, low and critical limits
  and produces the alarm and critical levels.
  Assumes temperature and limits are on the same clock as clk_i.
*/
`timescale 1ns/10ps
module limit_compare (
  input  wire logic clk_i,   // System clock.
  input  wire logic rst_i,   // Synchronous reset, active high.
  limit_if.cmp      lim      // Limits in, alarm levels out.
);
  import tsens_pkg::*;

  localparam int unsigned EXT_W = DATA_W + 1;

  logic signed [EXT_W-1:0] t_x;
  logic signed [EXT_W-1:0] high_x;
  logic signed [EXT_W-1:0] low_x;
  logic signed [EXT_W-1:0] crit_x;
  logic signed [EXT_W-1:0] hyst_x;
  logic                    over_set;
  logic                    over_clr;
  logic                    under_set;
  logic                    under_clr;
  logic                    crit_set;
  logic                    crit_clr;
  logic                    over_ff;
  logic                    under_ff;
  logic                    crit_ff;
  logic                    alarm_ff;
  logic                    nxt_over;
  logic                    nxt_under;
  logic                    new_cross;

  // Sign extension keeps limit minus hysteresis from wrapping.
  assign t_x      = {lim.temp[DATA_W-1], lim.temp};
  assign high_x   = {lim.high[DATA_W-1], lim.high};
  assign low_x    = {lim.low[DATA_W-1], lim.low};
  assign crit_x   = {lim.crit[DATA_W-1], lim.crit};
  // Hysteresis counts whole degrees, so it is scaled up to temperature LSBs.
  assign hyst_x   = {{(EXT_W-HYST_W-DEG_LSB){1'b0}}, lim.hyst, {DEG_LSB{1'b0}}};

  assign over_set  = t_x > high_x;
  assign over_clr  = t_x < (high_x - hyst_x);
  assign under_set = t_x < low_x;
  assign under_clr = t_x > (low_x + hyst_x);
  assign crit_set  = t_x > crit_x;
  assign crit_clr  = t_x < (crit_x - hyst_x);

  assign nxt_over  = over_set | (over_ff & ~over_clr);
  assign nxt_under = under_set | (under_ff & ~under_clr);
  assign new_cross = (nxt_over & ~over_ff) | (nxt_under & ~under_ff);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      over_ff  <= 1'b0;
      under_ff <= 1'b0;
      crit_ff  <= 1'b0;
    end
    else if (lim.ce)
    begin
      over_ff  <= nxt_over;
      under_ff <= nxt_under;
      crit_ff  <= crit_set | (crit_ff & ~crit_clr);
    end
  end

  // Interrupt mode: a fresh crossing wins over a read in the same cycle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      alarm_ff <= 1'b0;
    else if (lim.ce)
    begin
      if (lim.cmp_mode)
        alarm_ff <= nxt_over | nxt_under;
      else if (new_cross)
        alarm_ff <= 1'b1;
      else if (lim.rd_evt)
        alarm_ff <= 1'b0;
    end
  end

  assign lim.alarm    = alarm_ff;
  assign lim.critical = crit_ff;
endmodule

/* File: hdl/temp_sensor_spi.sv */
/*
  Serial register interface of the temperature sensor with its limit
  registers. Decodes the command byte, loads written registers, shifts
  read data out, supports continuous temperature reads, frame sync,
  three-wire use with chip select held low for continuous reads only, and the reset by a long run of ones on the data input.
  Assumes serial clock, chip select and data input come from outside the
  clock domain; temperature and mode come from logic on clk_i.
*/
`timescale 1ns/10ps
module temp_sensor_spi #(
  parameter logic [7:0] IDENT_VALUE = tsens_pkg::IDENT_DEF  // Arbitrary value.
) (
  input  wire logic          clk_i,      // System clock, 50 MHz.
  input  wire logic          rst_i,      // Synchronous reset, active high.
  input  wire logic          ce_i,       // Clock enable; low freezes all state.
  input  wire logic          sclk_i,     // Serial clock pin.
  input  wire logic          cs_n_i,     // Chip select pin, active low.
  input  wire logic          din_i,      // Serial data in pin.
  input  wire tsens_pkg::word_t temp_i,  // Measured temperature, twos complement.
  input  wire logic          cmp_mode_i, // One selects comparator mode.
  output      logic          dout_o,     // Serial data out.
  output      logic          dout_oe_o,  // High while data out is driven.
  output      logic          alarm_o,    // Alarm level, active high.
  output      logic          critical_output_o // Critical level, active high.
);
  import tsens_pkg::*;

  function automatic logic is_wide(input reg_addr_t a);
    is_wide = (a == ADDR_TEMP) || (a == ADDR_CRIT) ||
              (a == ADDR_HIGH) || (a == ADDR_LOW);
  endfunction

  limit_if lim ();

  logic [1:0]          sclk_sync_ff;
  logic [1:0]          cs_sync_ff;
  logic [1:0]          din_sync_ff;
  logic                sclk_d_ff;
  logic                cs_d_ff;
  link_state_t         state_ff;
  logic [BITCNT_W-1:0] bit_cnt_ff;
  logic [BITCNT_W-1:0] out_cnt_ff;
  logic [ONES_W-1:0]   ones_cnt_ff;
  logic [DATA_W-2:0]   in_sr_ff;
  word_t               out_sr_ff;
  reg_addr_t           addr_ff;
  logic                cont_ff;
  logic                rd_evt_ff;
  logic                dout_ff;
  logic                oe_ff;
  word_t               critical_limit_ff;
  logic [7:0]          hysteresis_setting_ff;
  word_t               high_limit_ff;
  word_t               low_limit_ff;

  logic                sclk_s;
  logic                cs_s;
  logic                din_s;
  logic                rise;
  logic                fall;
  logic                cs_fall;
  logic                if_reset;
  logic [7:0]          cmd_byte;
  reg_addr_t           cmd_addr;
  logic                direction_bit;
  logic                continuous_read_bit;
  logic                command_top_bit;
  logic                cmd_is_cont;
  logic                cmd_done;
  logic                data_last;
  word_t               wdata;
  word_t               rd_data;
  logic                wr_strobe;
  logic                shift_out;

  // Two-flop synchronisers; the second stage feeds logic, with a delayed copy for serial clock and chip select.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sclk_sync_ff <= 2'h3;
      cs_sync_ff   <= 2'h3;
      din_sync_ff  <= 2'h0;
      sclk_d_ff    <= 1'b1;
      cs_d_ff      <= 1'b1;
    end
    else if (ce_i)
    begin
      sclk_sync_ff <= {sclk_sync_ff[0], sclk_i};
      cs_sync_ff   <= {cs_sync_ff[0], cs_n_i};
      din_sync_ff  <= {din_sync_ff[0], din_i};
      sclk_d_ff    <= sclk_sync_ff[1];
      cs_d_ff      <= cs_sync_ff[1];
    end
  end

  assign sclk_s   = sclk_sync_ff[1];
  assign cs_s     = cs_sync_ff[1];
  assign din_s    = din_sync_ff[1];
  assign rise     = ce_i & sclk_s & ~sclk_d_ff;
  assign fall     = ce_i & ~sclk_s & sclk_d_ff;
  assign cs_fall  = ce_i & ~cs_s & cs_d_ff;
  assign if_reset = rise & din_s & (ones_cnt_ff == ONES_RUN - 6'h1);

  assign cmd_byte            = {in_sr_ff[6:0], din_s};
  assign cmd_addr            = cmd_byte[ADDR_MSB:ADDR_LSB];
  assign direction_bit       = cmd_byte[DIR_BIT];
  assign continuous_read_bit = cmd_byte[CONT_BIT];
  assign command_top_bit     = cmd_byte[CMD_TOP_BIT];
  assign cmd_is_cont = continuous_read_bit && (cmd_byte == CONT_CMD);
  assign cmd_done    = rise & ~cs_s & ~if_reset & (state_ff == ST_CMD) &
                       (bit_cnt_ff == BYTE_LAST);
  assign data_last   = bit_cnt_ff == (is_wide(addr_ff) ? WORD_LAST : BYTE_LAST);
  assign wdata       = {in_sr_ff, din_s};
  assign wr_strobe   = rise & ~cs_s & ~if_reset & (state_ff == ST_WRITE) & data_last;
  assign shift_out   = fall & ~cs_s & ((state_ff == ST_READ) || (state_ff == ST_CONT));

  // Eight-bit registers sit in the upper byte so the MSB leaves first.
  always_comb
  begin
    rd_data = '0;
    unique case (cmd_addr)
      ADDR_TEMP:  rd_data = temp_i;
      ADDR_IDENT: rd_data = {IDENT_VALUE, 8'h00};
      ADDR_CRIT:  rd_data = critical_limit_ff;
      ADDR_HYST:  rd_data = {hysteresis_setting_ff, 8'h00};
      ADDR_HIGH:  rd_data = high_limit_ff;
      ADDR_LOW:   rd_data = low_limit_ff;
      default:    rd_data = '0;
    endcase
  end

  // Run of ones on the data input, counted on serial clock rising edges.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ones_cnt_ff <= '0;
    else if (rise)
      ones_cnt_ff <= (din_s && !if_reset) ? ones_cnt_ff + 6'h1 : '0;
  end

  // Command, write and read sequencing.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || if_reset)
    begin
      state_ff   <= ST_CMD;
      bit_cnt_ff <= '0;
      in_sr_ff   <= '0;
      addr_ff    <= '0;
      cont_ff    <= 1'b0;
    end
    else if (ce_i)
    begin
      if (cs_s)
      begin
        state_ff   <= cont_ff ? ST_CONT : ST_CMD;
        bit_cnt_ff <= '0;
      end
      else if (rise)
      begin
        in_sr_ff   <= wdata[DATA_W-2:0];
        bit_cnt_ff <= bit_cnt_ff + 5'h1;
        unique case (state_ff)
          ST_CMD:
            if (bit_cnt_ff == BYTE_LAST)
            begin
              bit_cnt_ff <= '0;
              addr_ff    <= cmd_addr;
              if (command_top_bit)
                state_ff <= ST_DONE;
              else if (cmd_is_cont)
              begin
                state_ff <= ST_CONT;
                cont_ff  <= 1'b1;
              end
              else if (direction_bit)
                state_ff <= ST_READ;
              else
                state_ff <= ST_WRITE;
            end
          ST_WRITE, ST_READ:
            if (data_last)
              state_ff <= ST_DONE;
          ST_CONT, ST_DONE:
            bit_cnt_ff <= '0;
        endcase
      end
    end
  end

  // Register file; the long run of ones restores power-on values.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || if_reset)
    begin
      critical_limit_ff     <= CRIT_RST;
      hysteresis_setting_ff <= HYST_RST;
      high_limit_ff         <= HIGH_RST;
      low_limit_ff          <= LOW_RST;
    end
    else if (wr_strobe)
    begin
      unique case (addr_ff)
        ADDR_CRIT: critical_limit_ff     <= wdata;
        ADDR_HYST: hysteresis_setting_ff <= wdata[7:0];
        ADDR_HIGH: high_limit_ff         <= wdata;
        ADDR_LOW:  low_limit_ff          <= wdata;
        default:   ;
      endcase
    end
  end

  // Output shifter, advanced on falling serial clock edges.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || if_reset)
    begin
      out_sr_ff  <= '0;
      out_cnt_ff <= '0;
      dout_ff    <= 1'b0;
    end
    else if (cmd_done && (cmd_is_cont || direction_bit))
    begin
      out_sr_ff  <= rd_data;
      out_cnt_ff <= '0;
    end
    else if (cs_fall && cont_ff)
    begin
      dout_ff    <= temp_i[DATA_W-1];
      out_sr_ff  <= {temp_i[DATA_W-2:0], 1'b0};
      out_cnt_ff <= 5'h1;
    end
    else if (shift_out)
    begin
      dout_ff    <= out_sr_ff[DATA_W-1];
      out_sr_ff  <= {out_sr_ff[DATA_W-2:0], 1'b0};
      out_cnt_ff <= out_cnt_ff + 5'h1;
      if (cont_ff && (out_cnt_ff == WORD_LAST))
      begin
        out_sr_ff  <= temp_i;
        out_cnt_ff <= '0;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_evt_ff <= 1'b0;
      oe_ff     <= 1'b0;
    end
    else if (ce_i)
    begin
      rd_evt_ff <= cmd_done & ~command_top_bit & (cmd_is_cont | direction_bit);
      oe_ff     <= ~cs_s;
    end
  end

  assign lim.ce       = ce_i;
  assign lim.temp     = temp_i;
  assign lim.high     = high_limit_ff;
  assign lim.low      = low_limit_ff;
  assign lim.crit     = critical_limit_ff;
  assign lim.hyst     = hysteresis_setting_ff[HYST_W-1:0];
  assign lim.cmp_mode = cmp_mode_i;
  assign lim.rd_evt   = rd_evt_ff;

  limit_compare u_limit (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .lim   (lim.cmp)
  );

  assign dout_o            = dout_ff;
  assign dout_oe_o         = oe_ff;
  assign alarm_o           = lim.alarm;
  assign critical_output_o = lim.critical;
endmodule

/* File: verification/spi_master_model.sv */
/*
  Serial master on the far side of the sensor link, sampling on rising edges.
  Assumes one caller at a time; frames carry up to 32 bits, MSB first.
*/
`timescale 1ns/10ps
module spi_master_model (
  output logic      sclk_o, // Serial clock.
  output logic      cs_n_o, // Chip select, active low.
  output logic      din_o,  // Data to the device.
  input  wire logic dout_i  // Data from the device.
);
  initial
  begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    din_o  = 1'b0;
  end

  // Edges sit 5 ns off the system clock so the sampling order never matters.
  task automatic frame(input int n, input logic [31:0] tx, output logic [32:0] rx);
    rx = '0;
    #(15 - $time % 10);
    cs_n_o = 1'b0;
    #100;
    rx = {rx[31:0], dout_i};
    for (int i = n - 1; i >= 0; i--)
    begin
      sclk_o = 1'b0;
      din_o  = tx[i];
      #80;
      sclk_o = 1'b1;
      #70;
      rx = {rx[31:0], dout_i};
      #10;
    end
    cs_n_o = 1'b1;
    din_o  = ~din_o;
    #100;
  endtask
endmodule

/* File: verification/temp_sensor_spi_checker.sv */
/*
  Port checker of the serial register block.
  Assumes it is bound to temp_sensor_spi and sees only its ports.
*/
`timescale 1ns/10ps
module temp_sensor_spi_checker (
  input wire logic             clk_i,            // System clock.
  input wire logic             rst_i,            // Reset.
  input wire logic             ce_i,             // Clock enable.
  input wire logic             sclk_i,           // Serial clock.
  input wire logic             cs_n_i,           // Chip select.
  input wire logic             din_i,            // Serial data in.
  input wire tsens_pkg::word_t temp_i,           // Temperature.
  input wire logic             cmp_mode_i,       // Comparator mode.
  input wire logic             dout_o,           // Serial data out.
  input wire logic             dout_oe_o,        // Output enable.
  input wire logic             alarm_o,          // Alarm level.
  input wire logic             critical_output_o // Critical level.
);
  import tsens_pkg::*;
  logic       sclk_q;
  logic       cs_q;
  logic       mode_q;
  word_t      temp_q;
  logic [3:0] since_fall_ff;
  logic [3:0] since_act_ff;
  wire logic  fall_seen = (sclk_q & ~sclk_i) | (cs_q ^ cs_n_i);
  wire logic  act_seen  = (~sclk_q & sclk_i) | (temp_q != temp_i) | (mode_q != cmp_mode_i);

  // Cycles since the last serial clock fall or chip select edge, and since any cause.
  always_ff @(posedge clk_i)
  begin
    sclk_q        <= sclk_i;
    cs_q          <= cs_n_i;
    mode_q        <= cmp_mode_i;
    temp_q        <= temp_i;
    since_fall_ff <= (rst_i | fall_seen) ? 4'h0 : since_fall_ff + {3'h0, ~&since_fall_ff};
    since_act_ff  <= (rst_i | act_seen) ? 4'h0 : since_act_ff + {3'h0, ~&since_act_ff};
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);

  sequence s_cs_fall;
    $fell(cs_n_i);
  endsequence
  sequence s_oe_up;
    ##[1:5] dout_oe_o;
  endsequence

  property p_dout_edge;
    $changed(dout_o) |-> since_fall_ff <= 4'h5;
  endproperty
  property p_oe_on;
    s_cs_fall |-> s_oe_up;
  endproperty
  property p_oe_off;
    $rose(cs_n_i) |-> ##[1:5] !dout_oe_o;
  endproperty
  property p_oe_low;
    cs_n_i [*5] |-> !dout_oe_o;
  endproperty
  property p_oe_high;
    !cs_n_i [*5] |-> dout_oe_o;
  endproperty
  property p_alarm_cause;
    $changed(alarm_o) |-> since_act_ff <= 4'h8;
  endproperty
  property p_crit_cause;
    $changed(critical_output_o) |-> since_act_ff <= 4'h8;
  endproperty
  property p_reset_quiet;
    $fell(rst_i) |-> !dout_oe_o && !alarm_o && !critical_output_o;
  endproperty

  a_dout_edge: assert property (p_dout_edge) else $error("data out moved off a falling edge");
  a_oe_on: assert property (p_oe_on) else $error("output not enabled after select");
  a_oe_off: assert property (p_oe_off) else $error("output still enabled after deselect");
  a_oe_low: assert property (p_oe_low) else $error("output enabled while deselected");
  a_oe_high: assert property (p_oe_high) else $error("output dropped while selected");
  a_alarm_cause: assert property (p_alarm_cause) else $error("alarm moved without cause");
  a_crit_cause: assert property (p_crit_cause) else $error("critical moved without cause");
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
endmodule

bind temp_sensor_spi temp_sensor_spi_checker u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
  .din_i(din_i), .temp_i(temp_i), .cmp_mode_i(cmp_mode_i), .dout_o(dout_o),
  .dout_oe_o(dout_oe_o), .alarm_o(alarm_o), .critical_output_o(critical_output_o)
);

/* File: verification/temp_sensor_spi_tb.sv */
/*
  Self-checking bench of the serial register block with a master model.
  Assumes the checker is bound in and ce_i stays high throughout.
*/
`timescale 1ns/10ps
module temp_sensor_spi_tb;
  import tsens_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        ce_i = 1'b1;
  word_t       temp_i = 16'h1000;
  logic        cmp_mode_i = 1'b1;
  logic        sclk;
  logic        cs_n;
  logic        din;
  logic        dout;
  logic        alarm;
  logic        crit;
  logic        oe;
  logic [32:0] rx;
  word_t       val;
  int          miscompares = 0;
  int          num_checks = 0;

  always #10 clk_i = ~clk_i;

  spi_master_model u_master (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout));

  temp_sensor_spi u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
    .temp_i(temp_i), .cmp_mode_i(cmp_mode_i), .dout_o(dout), .dout_oe_o(oe),
    .alarm_o(alarm), .critical_output_o(crit)
  );

  task automatic check(input word_t seen, input word_t exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] cmd, input word_t v, input bit w16);
    u_master.frame(w16 ? 24 : 16, w16 ? {8'h00, cmd, v} : {16'h0000, cmd, v[7:0]}, rx);
  endtask

  task automatic rd(input logic [7:0] cmd, input bit w16, output word_t v);
    u_master.frame(w16 ? 24 : 16, {cmd, 24'h00_0000} >> (w16 ? 8 : 16), rx);
    v = w16 ? rx[15:0] : {8'h00, rx[7:0]};
  endtask

  task automatic set_temp(input word_t t);
    @(posedge clk_i);
    temp_i <= t;
    repeat (6) @(posedge clk_i);
  endtask

  task automatic t_defaults();
    rd(8'h58, 0, val); check(val, {8'h00, IDENT_DEF});
    rd(8'h60, 1, val); check(val, 16'h4980);
    rd(8'h68, 0, val); check(val, 16'h0005);
    rd(8'h70, 1, val); check(val, 16'h2000);
    rd(8'h78, 1, val); check(val, 16'h0500);
  endtask

  // One degree is 16'h0080, so the default hysteresis spans 16'h0280.
  task automatic t_limits();
    word_t      temps [11] = '{16'h1000, 16'h2001, 16'h1f00, 16'h1d00, 16'h04ff, 16'h0700,
                               16'h0800, 16'h4981, 16'h4800, 16'h4600, 16'h1000};
    logic [1:0] exp [11] = '{2'b00, 2'b10, 2'b10, 2'b00, 2'b10, 2'b10,
                             2'b00, 2'b11, 2'b11, 2'b10, 2'b00};
    for (int i = 0; i < 11; i++)
    begin
      set_temp(temps[i]);
      check({14'h0000, alarm, crit}, {14'h0000, exp[i]});
    end
  endtask

  task automatic t_irq();
    @(posedge clk_i);
    cmp_mode_i <= 1'b0;
    set_temp(16'h2001);
    check({15'h0000, alarm}, 16'h0001);
    rd(8'h58, 0, val);
    repeat (4) @(posedge clk_i);
    check({15'h0000, alarm}, 16'h0000);
    set_temp(16'h1000);
    set_temp(16'h2001);
    check({15'h0000, alarm}, 16'h0001);
    cmp_mode_i <= 1'b1;
    set_temp(16'h1000);
  endtask

  task automatic t_write();
    wr(8'h30, 16'h1234, 1);
    wr(8'h38, 16'h8001, 1);
    wr(8'h20, 16'h7fff, 1);
    wr(8'h28, 16'h00a5, 0);
    wr(8'h18, 16'h0000, 0);
    wr(8'hb0, 16'h1111, 1);
    rd(8'h70, 1, val); check(val, 16'h1234);
    rd(8'h78, 1, val); check(val, 16'h8001);
    rd(8'h60, 1, val); check(val, 16'h7fff);
    rd(8'h68, 0, val); check(val, 16'h00a5);
    rd(8'h58, 0, val); check(val, {8'h00, IDENT_DEF});
  endtask

  task automatic t_cont();
    word_t vals [2] = '{16'ha5c3, 16'h3c5a};
    u_master.frame(8, 32'h0000_0054, rx);
    for (int i = 0; i < 2; i++)
    begin
      set_temp(vals[i]);
      u_master.frame(16, 32'h0000_0000, rx);
      u_master.frame(16, 32'h0000_0000, rx);
      check({rx[16], rx[15:1]}, vals[i]);
    end
    set_temp(16'h0000);
  endtask

  task automatic t_ones();
    u_master.frame(32, 32'hffff_ffff, rx);
    repeat (25000) @(posedge clk_i);
    rd(8'h70, 1, val); check(val, 16'h2000);
    t_defaults();
  endtask

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (100000) @(posedge clk_i);
    miscompares++;
    give_verdict();
  end

  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check({15'h0000, oe}, 16'h0000);
    t_defaults();
    t_limits();
    t_irq();
    t_write();
    t_cont();
    t_ones();
    give_verdict();
  end
endmodule
